// ### pkg/keypad_pkg.sv
`default_nettype none
// Shared constants and types for the keypad event encoder
package keypad_pkg;
  // Matrix geometry and line count
  localparam int NUM_ROWS    = 8;
  localparam int NUM_COLS    = 10;
  localparam int NUM_LINES   = 18;
  localparam int NUM_KEYS    = 80;
  localparam int QUEUE_DEPTH = 10;
  // Walker visits every key, then every line
  localparam int WALK_LAST   = NUM_KEYS + NUM_LINES - 1;

  // Timing, in ns, and derived cycle counts at the system clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int ROW_DWELL_NS  = 2000;
  localparam int DEBOUNCE_NS   = 50000;
  localparam int DETECT_MAX_NS = 25000;
  // Least time: round up
  localparam int ROW_DWELL_CYC =
    (ROW_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Nominal period: round down
  localparam int DEBOUNCE_CYC  = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int DETECT_MAX_CYC = DETECT_MAX_NS / CLK_PERIOD_NS;

  // Key code bases
  localparam logic [6:0] MAT_CODE_OFS  = 7'h01;
  localparam logic [6:0] LINE_CODE_OFS = 7'h11;

  // Register byte offsets
  localparam logic [5:0] ADDR_CTRL     = 6'h00;
  localparam logic [5:0] ADDR_LINE_SEL = 6'h04;
  localparam logic [5:0] ADDR_ENROLL   = 6'h08;
  localparam logic [5:0] ADDR_POLARITY = 6'h0C;
  localparam logic [5:0] ADDR_OUT_DATA = 6'h10;
  localparam logic [5:0] ADDR_OUT_DIR  = 6'h14;
  localparam logic [5:0] ADDR_LEVEL    = 6'h18;
  localparam logic [5:0] ADDR_COUNT    = 6'h1C;
  localparam logic [5:0] ADDR_EVENT    = 6'h20;

  // Control fields and reset values
  localparam int CTRL_EM_BIT     = 0;
  localparam int CTRL_MASK_LSB   = 8;
  localparam int CTRL_UNLOCK_LSB = 16;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_1F01;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [17:0] LINE_RST   = 18'h0_0000;
  localparam logic [17:0] LINE_IDLE  = 18'h3_FFFF; // Pulled-up pin level

  // One queued event byte
  typedef struct packed {
    logic       press;
    logic [6:0] code;
  } evt_t;
  localparam evt_t EVT_NONE = 8'h00;

  // Row scan states, one bit changes per step except SAMPLE back to IDLE
  typedef enum logic [1:0] {
    SC_IDLE   = 2'b00,
    SC_DRIVE  = 2'b01,
    SC_SAMPLE = 2'b11
  } scan_state_t;
endpackage
`default_nettype wire

// ### src/line_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module line_debounce
  import keypad_pkg::*;
(
  // Clock and control
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  input  wire logic                 i_tick,
  // Synchronised levels in, debounced out
  input  wire logic [NUM_LINES-1:0] i_level,
  output logic      [NUM_LINES-1:0] o_level
);
  logic [NUM_LINES-1:0] stage1_reg; // First stage, takes any level

  // two stages on the slow tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      // Idle pins read high; avoids a false edge after reset
      stage1_reg <= LINE_IDLE;
      o_level    <= LINE_IDLE;
    end else if (i_ce && i_tick) begin
      stage1_reg <= i_level;
      // Pass only bits stable across two ticks
      o_level <= (stage1_reg & ~(i_level ^ stage1_reg))
               | (o_level & (i_level ^ stage1_reg));
    end
  end
endmodule // line_debounce
`default_nettype wire

// ### src/event_queue.sv
`timescale 1ns/100ps
`default_nettype none
module event_queue
  import keypad_pkg::*;
(
  // Clock and control
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  // Push side
  input  wire logic       i_push,
  input  wire evt_t       i_data,
  // Pop side
  input  wire logic       i_pop,
  output evt_t            o_head,
  output logic [3:0]      o_count
);
  evt_t mem [QUEUE_DEPTH]; // Entry 0 is the oldest
  logic full;
  logic push_ok;
  logic pop_ok;

  assign full    = (o_count == 4'(QUEUE_DEPTH));
  // A full queue drops new events
  assign push_ok = i_push && !full;
  assign pop_ok  = i_pop && (o_count != 4'h0);
  assign o_head  = (o_count != 4'h0) ? mem[0] : EVT_NONE;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_count <= 4'h0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        mem[i] <= EVT_NONE;
      end
    end else if (i_ce) begin
      // Shift down on pop
      if (pop_ok) begin
        for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
          mem[i] <= mem[i+1];
        end
        mem[QUEUE_DEPTH-1] <= EVT_NONE;
      end
      // Write behind the last live entry
      if (push_ok && pop_ok) begin
        mem[o_count - 4'h1] <= i_data;
      end else if (push_ok) begin
        mem[o_count] <= i_data;
      end
      if (push_ok && !pop_ok) begin
        o_count <= o_count + 4'h1;
      end else if (pop_ok && !push_ok) begin
        o_count <= o_count - 4'h1;
      end
    end
  end
endmodule // event_queue
`default_nettype wire

// ### src/keypad_event_encoder.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - scan up to eight by ten keys
// - line joins matrix when select bit one
// - monitor selected matrix and inputs continuously
// - any line may be standalone input
// - matrix code row times ten plus column plus one
// - row inputs code 97 to 104
// - column inputs code 105 to 114
// - inputs share matrix event path
// - active high input press on rise
// - active low input press on fall
// - after press, watch for opposite level
// - bit seven marks press or release
// - locked with mode bit, skip inputs
// - input events offered for unlock keys
// - detect matrix key press or release within 25us
// - mask timer 31s, unlock timer 7s
// - bit seven one press, zero release
// - event queue holds ten bytes
// - two stage debounce on 50us clock
module keypad_event_encoder
  import keypad_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  // Avalon-MM slave
  input  wire logic [5:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Row lines [7:0] and column lines [17:8]
  input  wire logic [NUM_LINES-1:0] i_line_in,
  output logic      [NUM_LINES-1:0] o_line_out,
  output logic      [NUM_LINES-1:0] o_line_oe_n,
  // Lock logic side
  input  wire logic                 i_keypad_locked,
  output logic                      o_event_pulse,
  output evt_t                      o_event_byte,
  output logic      [3:0]           o_event_count,
  output logic      [4:0]           o_mask_secs,
  output logic      [2:0]           o_unlock_secs
);
  // Software registers
  logic [31:0]          ctrl_reg;     // Mode bit and timer settings
  logic [17:0]          line_sel_reg; // matrix_line_select
  logic [17:0]          enroll_reg;   // input_event_enroll
  logic [17:0]          polarity_reg; // One is active high
  logic [17:0]          out_data_reg; // Level for output lines
  logic [17:0]          out_dir_reg;  // One is output
  // Bus handshake
  logic                 req;
  logic                 done;
  logic [31:0]          wmask;
  logic [31:0]          rd_next;
  // Pin synchronisers and debounce
  logic [17:0]          sync1_reg;
  logic [17:0]          sync2_reg;
  logic [17:0]          level_db;
  logic [11:0]          tick_cnt_reg;
  logic                 tick_reg;
  // Scan state
  scan_state_t          scan_state_reg;
  logic [2:0]           row_ptr_reg;
  logic [7:0]           dwell_reg;
  logic [NUM_KEYS-1:0]  mat_now_reg;  // Current matrix key states
  // Walker and event path
  logic [6:0]           walk_reg;
  logic [WALK_LAST:0]   rep_reg;      // Last reported states
  logic [WALK_LAST:0]   now_all;
  logic [WALK_LAST:0]   elig_all;
  logic [17:0]          gpi_act;
  logic [17:0]          gpi_elig;
  logic [NUM_KEYS-1:0]  mat_elig;
  logic                 is_line;
  logic                 suppress;
  evt_t                 walk_evt;
  logic                 push_reg;
  evt_t                 push_data_reg;
  evt_t                 q_head;
  logic [3:0]           q_count;
  logic                 pop;

  // Request taken once waitrequest has been low for a cycle
  assign req  = i_avs_read || i_avs_write;
  assign done = req && !o_avs_waitrequest;
  assign pop  = done && i_avs_read && (i_avs_address == ADDR_EVENT);

  // Byte enables widened to a bit mask
  generate
    for (genvar b = 0; b < 4; b++) begin : g_be
      assign wmask[8*b +: 8] = {8{i_avs_byteenable[b]}};
    end
  endgenerate

  // Waitrequest drops for one cycle after a request appears
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_avs_waitrequest <= !(req && o_avs_waitrequest);
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (i_avs_address)
      ADDR_CTRL:     rd_next = ctrl_reg;
      ADDR_LINE_SEL: rd_next = {14'h0000, line_sel_reg};
      ADDR_ENROLL:   rd_next = {14'h0000, enroll_reg};
      ADDR_POLARITY: rd_next = {14'h0000, polarity_reg};
      ADDR_OUT_DATA: rd_next = {14'h0000, out_data_reg};
      ADDR_OUT_DIR:  rd_next = {14'h0000, out_dir_reg};
      ADDR_LEVEL:    rd_next = {14'h0000, level_db};
      ADDR_COUNT:    rd_next = {28'h000_0000, q_count};
      ADDR_EVENT:    rd_next = {24'h00_0000, q_head};
      default:       rd_next = 32'h0000_0000;
    endcase
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= rd_next;
    end
  end

  // Register writes land on the completing edge
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ctrl_reg     <= CTRL_RST;
      line_sel_reg <= LINE_RST;
      enroll_reg   <= LINE_RST;
      polarity_reg <= LINE_RST;
      out_data_reg <= LINE_RST;
      out_dir_reg  <= LINE_RST;
    end else if (i_ce && done && i_avs_write) begin
      unique case (i_avs_address)
        // timer fields, five and three bits
        ADDR_CTRL: begin
          ctrl_reg <= (ctrl_reg & ~(wmask & CTRL_WMASK))
                    | (i_avs_writedata & wmask & CTRL_WMASK);
        end
        ADDR_LINE_SEL: begin
          line_sel_reg <= (line_sel_reg & ~wmask[17:0])
                        | (i_avs_writedata[17:0] & wmask[17:0]);
        end
        ADDR_ENROLL: begin
          enroll_reg <= (enroll_reg & ~wmask[17:0])
                      | (i_avs_writedata[17:0] & wmask[17:0]);
        end
        ADDR_POLARITY: begin
          polarity_reg <= (polarity_reg & ~wmask[17:0])
                        | (i_avs_writedata[17:0] & wmask[17:0]);
        end
        ADDR_OUT_DATA: begin
          out_data_reg <= (out_data_reg & ~wmask[17:0])
                        | (i_avs_writedata[17:0] & wmask[17:0]);
        end
        ADDR_OUT_DIR: begin
          out_dir_reg <= (out_dir_reg & ~wmask[17:0])
                       | (i_avs_writedata[17:0] & wmask[17:0]);
        end
        // Read-only and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
  end

  // Timer settings go to the lock logic
  assign o_mask_secs   = ctrl_reg[CTRL_MASK_LSB +: 5];
  assign o_unlock_secs = ctrl_reg[CTRL_UNLOCK_LSB +: 3];

  // Two flip-flops on every pin before use
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      // Start at the pulled-up level, so no false edge follows reset
      sync1_reg <= LINE_IDLE;
      sync2_reg <= LINE_IDLE;
    end else if (i_ce) begin
      sync1_reg <= i_line_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Free running debounce tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      tick_cnt_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else if (i_ce) begin
      tick_reg <= (tick_cnt_reg == 12'(DEBOUNCE_CYC - 1));
      if (tick_cnt_reg == 12'(DEBOUNCE_CYC - 1)) begin
        tick_cnt_reg <= 12'h000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
    end
  end

  // Standalone input debounce
  line_debounce u_debounce (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_tick    (tick_reg),
    .i_level   (sync2_reg),
    .o_level   (level_db)
  );

  // row scan; a full pass takes about 16us
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      scan_state_reg <= SC_IDLE;
      row_ptr_reg    <= 3'h0;
      dwell_reg      <= 8'h00;
      mat_now_reg    <= '0;
    end else if (i_ce) begin
      unique case (scan_state_reg)
        SC_IDLE: begin
          dwell_reg <= 8'h00;
          if (line_sel_reg[row_ptr_reg]) begin
            scan_state_reg <= SC_DRIVE;
          end else begin
            // Unselected row holds no keys
            for (int c = 0; c < NUM_COLS; c++) begin
              mat_now_reg[int'(row_ptr_reg) * NUM_COLS + c] <= 1'b0;
            end
            row_ptr_reg <= row_ptr_reg + 3'h1;
          end
        end
        // Row held low while column levels settle
        SC_DRIVE: begin
          dwell_reg <= dwell_reg + 8'h01;
          if (dwell_reg == 8'(ROW_DWELL_CYC - 1)) begin
            scan_state_reg <= SC_SAMPLE;
          end
        end
        SC_SAMPLE: begin
          for (int c = 0; c < NUM_COLS; c++) begin
            mat_now_reg[int'(row_ptr_reg) * NUM_COLS + c] <=
              line_sel_reg[NUM_ROWS + c] && !sync2_reg[NUM_ROWS + c];
          end
          row_ptr_reg    <= row_ptr_reg + 3'h1;
          scan_state_reg <= SC_IDLE;
        end
        default: scan_state_reg <= SC_IDLE;
      endcase
    end
  end

  // Pin drive: scanned row low, output lines driven, rest released
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_line_out  <= LINE_RST;
      o_line_oe_n <= '1;
    end else if (i_ce) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (line_sel_reg[i]) begin
          o_line_out[i]  <= 1'b0;
          o_line_oe_n[i] <= !((i < NUM_ROWS)
                              && (3'(i) == row_ptr_reg)
                              && (scan_state_reg != SC_IDLE));
        end else begin
          // free lines as inputs or outputs
          o_line_out[i]  <= out_data_reg[i];
          o_line_oe_n[i] <= !out_dir_reg[i];
        end
      end
    end
  end

  // Eligibility per key and per line
  generate
    for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
      assign mat_elig[k] = line_sel_reg[k / NUM_COLS]
                        && line_sel_reg[NUM_ROWS + (k % NUM_COLS)];
    end
    for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
      // active high presses on a rise
      // active low presses on a fall
      assign gpi_act[l]  = polarity_reg[l] ? level_db[l] : !level_db[l];
      // needs enrolment, not matrix, not output
      assign gpi_elig[l] = enroll_reg[l] && !line_sel_reg[l]
                        && !out_dir_reg[l];
    end
  endgenerate

  assign now_all  = {gpi_act, mat_now_reg};
  assign elig_all = {gpi_elig, mat_elig};
  assign is_line  = (walk_reg >= 7'(NUM_KEYS));
  // lock with mode bit set skips inputs
  assign suppress = is_line && i_keypad_locked
                 && ctrl_reg[CTRL_EM_BIT];

  // Event byte for the walked position
  always_comb begin
    walk_evt.press = now_all[walk_reg];
    if (is_line) begin
      walk_evt.code = walk_reg + LINE_CODE_OFS;
    end else begin
      // row times ten plus col plus one
      walk_evt.code = walk_reg + MAT_CODE_OFS;
    end
  end

  // free-running walker pass of 98 cycles, independent of the scan
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      walk_reg      <= 7'h00;
      rep_reg       <= '0;
      push_reg      <= 1'b0;
      push_data_reg <= EVT_NONE;
      o_event_pulse <= 1'b0;
      o_event_byte  <= EVT_NONE;
    end else if (i_ce) begin
      push_reg      <= 1'b0;
      o_event_pulse <= 1'b0;
      if (walk_reg == 7'(WALK_LAST)) begin
        walk_reg <= 7'h00;
      end else begin
        walk_reg <= walk_reg + 7'h01;
      end
      if (now_all[walk_reg] != rep_reg[walk_reg]) begin
        // next report is the opposite level
        rep_reg[walk_reg] <= now_all[walk_reg];
        if (elig_all[walk_reg]) begin
          // every event reaches the lock logic
          o_event_pulse <= 1'b1;
          o_event_byte  <= walk_evt;
          // inputs share the matrix queue path
          push_reg      <= !suppress;
          push_data_reg <= walk_evt;
        end
      end
    end
  end

  // Event queue
  event_queue u_queue (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_push    (push_reg),
    .i_data    (push_data_reg),
    .i_pop     (pop),
    .o_head    (q_head),
    .o_count   (q_count)
  );

  // Count mirrored for the status logic
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_event_count <= 4'h0;
    end else if (i_ce) begin
      o_event_count <= q_count;
    end
  end
endmodule // keypad_event_encoder
`default_nettype wire

// ### tb/keypad_event_encoder_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module keypad_event_encoder_monitor
  import keypad_pkg::*;
(
  // Clock and reset
  input wire logic                 i_sys_clk,
  input wire logic                 i_rstn,
  // Bus handshake
  input wire logic                 i_avs_read,
  input wire logic                 i_avs_write,
  input wire logic                 o_avs_waitrequest,
  // Pins and events
  input wire logic [NUM_LINES-1:0] o_line_out,
  input wire logic [NUM_LINES-1:0] o_line_oe_n,
  input wire logic                 i_keypad_locked,
  input wire logic                 o_event_pulse,
  input wire evt_t                 o_event_byte,
  input wire logic [3:0]           o_event_count
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Rows pulled low; bench never sets rows as outputs
  logic [NUM_ROWS-1:0] rows_low;
  assign rows_low = ~o_line_oe_n[NUM_ROWS-1:0] & ~o_line_out[NUM_ROWS-1:0];
  chk_one_row: assert property ($onehot0(rows_low))
    else $error("two rows driven low at once");
  chk_wait_one: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  chk_wait_pulse: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_code_range: assert property (o_event_pulse |->
    o_event_byte.code inside {[7'h01:7'h50], [7'h61:7'h72]})
    else $error("event code outside key and input ranges");
  chk_byte_hold: assert property (
    !o_event_pulse && $past(i_rstn) |-> $stable(o_event_byte))
    else $error("event byte changed without a pulse");
  chk_count_max: assert property (o_event_count <= 4'hA)
    else $error("event count above ten");
  chk_count_step: assert property (
    $past(i_rstn) && $changed(o_event_count) |->
    (o_event_count == $past(o_event_count) + 4'h1 ||
     o_event_count == $past(o_event_count) - 4'h1))
    else $error("event count jumped by more than one");
  chk_push_seen: assert property (
    o_event_pulse && !i_keypad_locked && o_event_count == 4'h0 &&
    !i_avs_read |-> ##2 o_event_count != 4'h0)
    else $error("unlocked event not queued");
  chk_reset_out: assert property ($rose(i_rstn) |->
    o_avs_waitrequest && &o_line_oe_n && !o_event_pulse &&
    o_event_count == 4'h0 && o_event_byte == EVT_NONE)
    else $error("outputs not idle after reset");
  // Main scenarios reached
  cov_press: cover property (o_event_pulse && o_event_byte.press);
  cov_release: cover property (o_event_pulse && !o_event_byte.press);
  cov_locked: cover property (o_event_pulse && i_keypad_locked);
endmodule // keypad_event_encoder_monitor
bind keypad_event_encoder keypad_event_encoder_monitor mon_i (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n),
  .i_keypad_locked(i_keypad_locked), .o_event_pulse(o_event_pulse),
  .o_event_byte(o_event_byte), .o_event_count(o_event_count));
`default_nettype wire

// ### tb/keypad_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module keypad_switch_model
  import keypad_pkg::*;
(
  // Design pin drive
  input  wire logic [NUM_LINES-1:0] i_line_out,
  input  wire logic [NUM_LINES-1:0] i_line_oe_n,
  // Closed keys, index row*10+col, and button levels
  input  wire logic [NUM_KEYS-1:0]  i_keys,
  input  wire logic [NUM_LINES-1:0] i_btn,
  // Resolved pin levels
  output logic      [NUM_LINES-1:0] o_level
);
  // Wired AND over pull-ups: a released line reads high
  always_comb begin
    o_level = i_btn;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!i_line_oe_n[i] && !i_line_out[i]) o_level[i] = 1'b0;
    end
    for (int k = 0; k < NUM_KEYS; k++) begin
      if (i_keys[k] && !(o_level[k/10] && o_level[8+k%10])) begin
        o_level[k/10] = 1'b0;
        o_level[8+k%10] = 1'b0;
      end
    end
  end
endmodule // keypad_switch_model
`default_nettype wire

// ### tb/tb_keypad_event_encoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_keypad_event_encoder
  import keypad_pkg::*;
;
  localparam int BTN_LIM = 3 * DEBOUNCE_CYC + 200;
  // Clock, reset, bus
  logic                 clk, rstn, rd, wr, wait_req;
  logic [5:0]           addr;
  logic [31:0]          wdata, rdata;
  // Pins, lock side, events
  logic [NUM_LINES-1:0] line_in, line_out, line_oe_n, btn;
  logic [NUM_KEYS-1:0]  keys;
  logic                 locked, ev_pulse;
  evt_t                 ev_byte;
  logic [3:0]           ev_cnt;
  logic [4:0]           mask_secs;
  logic [2:0]           unl_secs;
  logic [7:0]           expq[$];
  int                   mismatches, n_tests;

  keypad_event_encoder keypad_event_encoder_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_line_in(line_in), .o_line_out(line_out), .o_line_oe_n(line_oe_n),
    .i_keypad_locked(locked), .o_event_pulse(ev_pulse),
    .o_event_byte(ev_byte), .o_event_count(ev_cnt),
    .o_mask_secs(mask_secs), .o_unlock_secs(unl_secs));
  keypad_switch_model keypad_switch_model_i (
    .i_line_out(line_out), .i_line_oe_n(line_oe_n), .i_keys(keys),
    .i_btn(btn), .o_level(line_in));

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access; waits without limit for waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // One wait cycle, then the completing edge
    check(32'(n), 32'h2);
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // Wait for an event pulse; note it if it should be queued
  task automatic ev_chk(input logic [7:0] e, input int lim, input logic qd);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ev_pulse !== 1'b1 && n < lim);
    check({31'h0, ev_pulse}, 32'h1);
    check({24'h0, ev_byte}, {24'h0, e});
    if (qd) expq.push_back(e);
  endtask
  // Count, then every queued byte in order, then empty
  task automatic drain();
    // Count output lags the push by two edges
    repeat (2) @(posedge clk);
    check({28'h0, ev_cnt}, 32'(expq.size()));
    rd_chk(ADDR_COUNT, 32'(expq.size()));
    while (expq.size() > 0)
      rd_chk(ADDR_EVENT, {24'h0, expq.pop_front()});
    rd_chk(ADDR_EVENT, 32'h0);
  endtask
  task automatic key_tap(input int r, input int c);
    logic [6:0] code;
    code = 7'(r * 10 + c + 1);
    @(posedge clk);
    keys[r*10+c] <= 1'b1;
    ev_chk({1'b1, code}, DETECT_MAX_CYC, 1'b1);
    keys[r*10+c] <= 1'b0;
    ev_chk({1'b0, code}, DETECT_MAX_CYC, 1'b1);
  endtask
  task automatic btn_tap(input int i, input logic hi);
    logic [6:0] code;
    code = 7'(97 + i);
    @(posedge clk);
    btn[i] <= hi;
    ev_chk({1'b1, code}, BTN_LIM, 1'b1);
    btn[i] <= !hi;
    ev_chk({1'b0, code}, BTN_LIM, 1'b1);
  endtask
  // Reset values, refused writes, unmapped place, timer fields
  task automatic t_reset();
    rd_chk(ADDR_LINE_SEL, 32'h0);
    rd_chk(ADDR_ENROLL, 32'h0);
    wr_reg(ADDR_COUNT, 32'hFFFF_FFFF);
    rd_chk(ADDR_COUNT, 32'h0);
    rd_chk(6'h3C, 32'h0);
    wr_reg(ADDR_CTRL, 32'hFFFF_FFFF);
    rd_chk(ADDR_CTRL, 32'h0007_1F01);
    check({24'h0, mask_secs, unl_secs}, 32'hFF);
    // Free line 17 as an output driving high
    wr_reg(ADDR_OUT_DATA, 32'h0002_0000);
    wr_reg(ADDR_OUT_DIR, 32'h0002_0000);
    repeat (2) @(posedge clk);
    check({14'h0, line_out & ~line_oe_n}, 32'h0002_0000);
    rd_chk(ADDR_OUT_DIR, 32'h0002_0000);
    wr_reg(ADDR_OUT_DIR, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0);
  endtask
  // Full matrix, corner and middle keys
  task automatic t_matrix();
    wr_reg(ADDR_LINE_SEL, 32'h0003_FFFF);
    key_tap(0, 0);
    key_tap(3, 2);
    key_tap(7, 9);
    drain();
  endtask
  // Standalone inputs of both polarities, row and column ends
  task automatic t_inputs();
    wr_reg(ADDR_LINE_SEL, 32'h0);
    // Polarity first, so levels settle before enrolment
    wr_reg(ADDR_POLARITY, 32'h0000_0101);
    btn[0] <= 1'b0;
    btn[8] <= 1'b0;
    repeat (3 * DEBOUNCE_CYC) @(posedge clk);
    rd_chk(ADDR_LEVEL, 32'h0003_FEFE);
    drain();
    wr_reg(ADDR_ENROLL, 32'h0002_0181);
    btn[5] <= 1'b0;
    btn_tap(0, 1'b1);
    btn_tap(7, 1'b0);
    btn_tap(8, 1'b1);
    btn_tap(17, 1'b0);
    drain();
  endtask
  // Locked with event mode: seen but not queued until mode cleared
  task automatic t_lock();
    locked <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h1);
    btn[17] <= 1'b0;
    ev_chk(8'hF2, BTN_LIM, 1'b0);
    wr_reg(ADDR_CTRL, 32'h0);
    btn[17] <= 1'b1;
    ev_chk(8'h72, BTN_LIM, 1'b1);
    drain();
    locked <= 1'b0;
  endtask

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    keys = '0;
    btn = '1;
    locked = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_matrix();
    t_inputs();
    t_lock();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule // tb_keypad_event_encoder
`default_nettype wire
